// file: core/plph_core.sv
// core end: link power state sequencing and turn-off handshake toward user logic
module plph_core (
    plph_if.core u,
    input wire logic train_done,
    input wire logic [1:0] link_gen,
    input wire logic async_refclk,
    input wire logic pwr_state_wr,
    input wire logic [1:0] pwr_state_data,
    input wire logic turn_off_msg,
    input wire logic link_idle,
    input wire logic l1_dllp_ack,
    output logic [7:0] fts_count,
    output logic pm_dllp_send,
    output logic turn_off_ack_send,
    output logic layers_enabled,
    output plph_pkg::plph_link_t link_state
);
    // ----------------------------------------------------------------
    // input synchronisers for link-side events
    // ----------------------------------------------------------------
    logic [1:0] train_sync;
    logic [1:0] async_sync;
    logic [1:0] l1ack_sync;
    // two flops each; only the second stage is read
    always_ff @(posedge u.core_clk or negedge u.nrst) begin
        if (!u.nrst) begin
            train_sync <= 2'h0;
            async_sync <= 2'h0;
            l1ack_sync <= 2'h0;
        end else begin
            train_sync <= {train_sync[0], train_done};
            async_sync <= {async_sync[0], async_refclk};
            l1ack_sync <= {l1ack_sync[0], l1_dllp_ack};
        end
    end
    wire trained = train_sync[1];
    wire refclk_async = async_sync[1];
    wire l1_acked = l1ack_sync[1];

    // ----------------------------------------------------------------
    // decoding
    // ----------------------------------------------------------------
    logic [1:0] pwr_state;
    logic in_pkt;
    logic [7:0] idle_cnt;
    plph_pkg::plph_to_t to_state;
    plph_pkg::plph_link_t next_link;
    // non-D0 covers D1, D2 and D3-hot
    function automatic logic is_low_power(input logic [1:0] s);
        return s != plph_pkg::PWR_D0;
    endfunction
    wire low_power = is_low_power(pwr_state);
    wire next_low_power = is_low_power(pwr_state_wr ? pwr_state_data : pwr_state);
    // active-state L0s only for synchronous clocking, gen1/gen2 builds
    wire l0s_allowed = !refclk_async && (link_gen != plph_pkg::GEN3);
    wire l0s_entry = l0s_allowed && link_idle && (idle_cnt == plph_pkg::L0S_IDLE_CYC);
    wire ack_seen = (to_state == plph_pkg::PLPH_TO_WAIT) && u.power_down_ack;
    wire handshake_done = to_state == plph_pkg::PLPH_TO_DONE;
    wire beat = u.req_valid && u.requester_request_ready;
    // a transfer already started keeps ready high until its last beat
    wire next_in_pkt = beat ? !u.req_last : in_pkt;
    wire next_ready = !handshake_done && (link_state != plph_pkg::PLPH_LINK_DOWN)
        && (!next_low_power || next_in_pkt);

    // link state selection; ASPM L1 never entered, only programmed L1
    always_comb begin
        next_link = link_state;
        case (link_state)
            plph_pkg::PLPH_LINK_DOWN: if (trained) next_link = plph_pkg::PLPH_LINK_L0;
            plph_pkg::PLPH_LINK_L0: begin
                if (turn_off_msg) next_link = plph_pkg::PLPH_LINK_L23;
                else if (low_power && !in_pkt) next_link = plph_pkg::PLPH_LINK_L1;
                else if (l0s_entry) next_link = plph_pkg::PLPH_LINK_L0S;
            end
            plph_pkg::PLPH_LINK_L0S: begin
                if (!link_idle || turn_off_msg || low_power) next_link = plph_pkg::PLPH_LINK_L0;
            end
            plph_pkg::PLPH_LINK_L1: begin
                if (turn_off_msg) next_link = plph_pkg::PLPH_LINK_L23;
                else if (!low_power) next_link = plph_pkg::PLPH_LINK_L0;
            end
            plph_pkg::PLPH_LINK_L23: if (handshake_done) next_link = plph_pkg::PLPH_LINK_OFF;
            plph_pkg::PLPH_LINK_OFF: next_link = plph_pkg::PLPH_LINK_OFF;
            default: next_link = plph_pkg::PLPH_LINK_DOWN;
        endcase
        if (!trained && link_state != plph_pkg::PLPH_LINK_OFF) next_link = plph_pkg::PLPH_LINK_DOWN;
    end

    // ----------------------------------------------------------------
    // state registers
    // ----------------------------------------------------------------
    // programmed power state and request-stream throttle
    always_ff @(posedge u.core_clk or negedge u.nrst) begin
        if (!u.nrst) begin
            pwr_state <= plph_pkg::PWR_D0;
            u.function_power_state <= plph_pkg::PWR_D0;
            in_pkt <= 1'b0;
            u.requester_request_ready <= 1'b0;
        end else begin
            if (pwr_state_wr) pwr_state <= pwr_state_data;
            u.function_power_state <= pwr_state_wr ? pwr_state_data : pwr_state;
            in_pkt <= next_in_pkt;
            u.requester_request_ready <= next_ready;
        end
    end

    // idle counter for L0s entry
    always_ff @(posedge u.core_clk or negedge u.nrst) begin
        if (!u.nrst) idle_cnt <= 8'h00;
        else if (!link_idle || link_state != plph_pkg::PLPH_LINK_L0) idle_cnt <= 8'h00;
        else if (idle_cnt != plph_pkg::L0S_IDLE_CYC) idle_cnt <= idle_cnt + 8'h01;
    end

    // link state and link-facing strobes
    always_ff @(posedge u.core_clk or negedge u.nrst) begin
        if (!u.nrst) begin
            link_state <= plph_pkg::PLPH_LINK_DOWN;
            pm_dllp_send <= 1'b0;
            layers_enabled <= 1'b1;
            fts_count <= plph_pkg::FTS_COUNT;
        end else begin
            link_state <= next_link;
            // keep requesting L1 until the partner answers
            pm_dllp_send <= (next_link == plph_pkg::PLPH_LINK_L1) && !l1_acked;
            layers_enabled <= !(next_link == plph_pkg::PLPH_LINK_OFF);
            fts_count <= plph_pkg::FTS_COUNT;
        end
    end

    // turn-off handshake: request held until ack, then dropped next cycle
    always_ff @(posedge u.core_clk or negedge u.nrst) begin
        if (!u.nrst) begin
            to_state <= plph_pkg::PLPH_TO_IDLE;
            u.turn_off_notice <= 1'b0;
            turn_off_ack_send <= 1'b0;
        end else begin
            turn_off_ack_send <= ack_seen;
            case (to_state)
                plph_pkg::PLPH_TO_IDLE: if (turn_off_msg) begin
                    to_state <= plph_pkg::PLPH_TO_WAIT;
                    u.turn_off_notice <= 1'b1;
                end
                plph_pkg::PLPH_TO_WAIT: if (ack_seen) begin
                    to_state <= plph_pkg::PLPH_TO_DONE;
                    u.turn_off_notice <= 1'b0;
                end
                plph_pkg::PLPH_TO_DONE: to_state <= plph_pkg::PLPH_TO_DONE;
                default: to_state <= plph_pkg::PLPH_TO_IDLE;
            endcase
        end
    end
endmodule

// file: inc/plph_pkg.sv
// package of constants and types shared by both ends of the power-management handshake
// ----------------------------------------------------------------
// Behaviour
// - advertise fast training count of 255
// - integrator ensures enough training sequences received
// - autonomous L0s support, never active-state L1
// - no active-state power management when non-synchronous
// - L0s only for first/second generation builds
// - support L0, L1, L3 programmed states
// - L0 only after link training completes
// - enter L1 when programmed to D1/D2/D3-hot
// - present programmed power state to user
// - drop request ready when non-D0, finish transfer
// - endpoint user sends no requests when non-D0
// - root port user sends no requests when non-D0
// - exchange L1 link packets autonomously
// - stall user requests while non-D0
// - turn-off message drives link toward L23 ready
// - hold power-down request until acknowledge
// - user finishes packet, then acknowledges power-down
// - send turn-off acknowledge on user acknowledge
// - after handshake close interfaces, disable layers
// ----------------------------------------------------------------
package plph_pkg;
    // advertised fast-training-sequence count
    localparam logic [7:0] FTS_COUNT = 8'h00_FF;
    // device power state encoding
    localparam logic [1:0] PWR_D0 = 2'h0;
    localparam logic [1:0] PWR_D1 = 2'h1;
    localparam logic [1:0] PWR_D2 = 2'h2;
    localparam logic [1:0] PWR_D3HOT = 2'h3;
    // link generation encoding
    localparam logic [1:0] GEN3 = 2'h2;
    // idle cycles before the device tries active-state L0s
    localparam int L0S_IDLE_NS = 2000;
    localparam int CLK_NS = 40;
    localparam logic [7:0] L0S_IDLE_CYC = 8'((L0S_IDLE_NS + CLK_NS - 1) / CLK_NS);
    // link power states, one-hot
    typedef enum logic [5:0] {
        PLPH_LINK_DOWN = 6'h01,
        PLPH_LINK_L0 = 6'h02,
        PLPH_LINK_L0S = 6'h04,
        PLPH_LINK_L1 = 6'h08,
        PLPH_LINK_L23 = 6'h10,
        PLPH_LINK_OFF = 6'h20
    } plph_link_t;
    // turn-off handshake states, one-hot
    typedef enum logic [2:0] {
        PLPH_TO_IDLE = 3'h1,
        PLPH_TO_WAIT = 3'h2,
        PLPH_TO_DONE = 3'h4
    } plph_to_t;
endpackage

// file: inc/plph_if.sv
// interface joining the core end and the user end of the power handshake
interface plph_if (
    input wire logic core_clk,
    input wire logic nrst
);
    logic [1:0] function_power_state;
    logic requester_request_ready;
    logic turn_off_notice;
    logic power_down_ack;
    logic req_valid;
    logic req_last;
    modport core (
        input core_clk,
        input nrst,
        output function_power_state,
        output requester_request_ready,
        output turn_off_notice,
        input power_down_ack,
        input req_valid,
        input req_last
    );
    modport user (
        input core_clk,
        input nrst,
        input function_power_state,
        input requester_request_ready,
        input turn_off_notice,
        output power_down_ack,
        output req_valid,
        output req_last
    );
endinterface

// file: core/plph_user.sv
// user end: issues request packets and answers the power-down request
module plph_user (
    plph_if.user u,
    input wire logic send_req,
    input wire logic [3:0] req_beats,
    output logic busy,
    output logic powered_down
);
    logic [3:0] beats_left;
    logic quiesce;
    wire stalled = u.function_power_state != plph_pkg::PWR_D0;
    wire beat = u.req_valid && u.requester_request_ready;
    // new packets only in D0 and with no turn-off pending
    wire start = send_req && !u.req_valid && !stalled && !quiesce && !u.turn_off_notice;
    wire last_beat = beat && (beats_left == 4'h1);
    // ----------------------------------------------------------------
    // request stream driver
    // ----------------------------------------------------------------
    always_ff @(posedge u.core_clk or negedge u.nrst) begin
        if (!u.nrst) begin
            u.req_valid <= 1'b0;
            u.req_last <= 1'b0;
            beats_left <= 4'h0;
            busy <= 1'b0;
        end else begin
            if (start) begin
                u.req_valid <= 1'b1;
                beats_left <= (req_beats == 4'h0) ? 4'h1 : req_beats;
                u.req_last <= req_beats <= 4'h1;
            end else if (last_beat) begin
                u.req_valid <= 1'b0;
                u.req_last <= 1'b0;
                beats_left <= 4'h0;
            end else if (beat) begin
                beats_left <= beats_left - 4'h1;
                u.req_last <= beats_left == 4'h2;
            end
            busy <= start || (u.req_valid && !last_beat);
        end
    end
    // ----------------------------------------------------------------
    // power-down answer: ack only once no packet is in flight
    // ----------------------------------------------------------------
    always_ff @(posedge u.core_clk or negedge u.nrst) begin
        if (!u.nrst) begin
            quiesce <= 1'b0;
            u.power_down_ack <= 1'b0;
            powered_down <= 1'b0;
        end else begin
            if (u.turn_off_notice) quiesce <= 1'b1;
            u.power_down_ack <= u.turn_off_notice && !u.req_valid && !u.power_down_ack;
            if (u.power_down_ack) powered_down <= 1'b1; // committed to power-off
        end
    end
endmodule

// file: tb/plph_monitor.sv
// checker for the handshake signals between the core end and the user end
module plph_monitor (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic [1:0] function_power_state,
    input wire logic requester_request_ready,
    input wire logic turn_off_notice,
    input wire logic power_down_ack,
    input wire logic req_valid,
    input wire logic req_last
);
    // ----------------------------------------
    // helpers and properties
    // ----------------------------------------
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    logic pkt_open;
    logic off_done;
    // open packet and finished turn-off both gate the ready line
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pkt_open <= 1'b0;
            off_done <= 1'b0;
        end else begin
            if (req_valid && requester_request_ready) begin
                pkt_open <= !req_last;
            end
            if (turn_off_notice && power_down_ack) begin
                off_done <= 1'b1;
            end
        end
    end
    sequence s_notice_up;
        !turn_off_notice ##1 turn_off_notice;
    endsequence
    sequence s_ack_taken;
        turn_off_notice && power_down_ack;
    endsequence
    // ready and power state move on the same edge, so the check is same-cycle
    ready_nond0_a: assert property (
        function_power_state != plph_pkg::PWR_D0 && !pkt_open |-> !requester_request_ready)
        else $error("ready high while not in D0");
    req_start_d0_a: assert property (
        !req_valid && function_power_state != plph_pkg::PWR_D0 |=> !req_valid)
        else $error("new request started while not in D0");
    notice_hold_a: assert property (turn_off_notice && !power_down_ack |=> turn_off_notice)
        else $error("power-down request dropped early");
    notice_release_a: assert property (s_ack_taken |=> !turn_off_notice)
        else $error("power-down request not dropped after ack");
    one_shot_a: assert property (off_done |-> !turn_off_notice)
        else $error("power-down request after finished handshake");
    off_ready_a: assert property (off_done |=> !requester_request_ready)
        else $error("ready high after turn-off");
    ack_bound_a: assert property (s_notice_up |-> ##[0:40] power_down_ack)
        else $error("no acknowledge to power-down request");
    ack_idle_a: assert property (power_down_ack |-> !req_valid && !pkt_open)
        else $error("acknowledge with packet in flight");
    ack_pulse_a: assert property (power_down_ack |=> !power_down_ack)
        else $error("acknowledge longer than one cycle");
    beat_hold_a: assert property (
        req_valid && !requester_request_ready |=> req_valid && $stable(req_last))
        else $error("request beat withdrawn before acceptance");
endmodule

// file: tb/pcie_link_power_handshake_tb.sv
// self-checking bench: core end and user end joined by the handshake interface
module pcie_link_power_handshake_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, nrst, train_done, async_refclk, pwr_state_wr, turn_off_msg, link_idle, l1_dllp_ack;
    logic send_req, pm_dllp_send, turn_off_ack_send, layers_enabled, busy, powered_down, ack_seen;
    logic [1:0] link_gen;
    logic [1:0] pwr_state_data;
    logic [3:0] req_beats;
    logic [7:0] fts_count;
    plph_pkg::plph_link_t link_state;
    int n_errors = 0;
    int checks_done = 0;
    int i;
    plph_if u_if (.core_clk(core_clk), .nrst(nrst));
    plph_core plph_core_inst (.u(u_if), .train_done(train_done), .link_gen(link_gen),
        .async_refclk(async_refclk), .pwr_state_wr(pwr_state_wr), .pwr_state_data(pwr_state_data),
        .turn_off_msg(turn_off_msg), .link_idle(link_idle), .l1_dllp_ack(l1_dllp_ack),
        .fts_count(fts_count), .pm_dllp_send(pm_dllp_send), .turn_off_ack_send(turn_off_ack_send),
        .layers_enabled(layers_enabled), .link_state(link_state));
    plph_user plph_user_inst (.u(u_if), .send_req(send_req), .req_beats(req_beats), .busy(busy),
        .powered_down(powered_down));
    plph_monitor plph_monitor_inst (.core_clk(core_clk), .nrst(nrst),
        .function_power_state(u_if.function_power_state), .requester_request_ready(u_if.requester_request_ready),
        .turn_off_notice(u_if.turn_off_notice), .power_down_ack(u_if.power_down_ack),
        .req_valid(u_if.req_valid), .req_last(u_if.req_last));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // inputs move on the falling edge, away from the sampling edge
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic wait_link(input plph_pkg::plph_link_t st);
        for (i = 0; i < 200 && link_state !== st; i++) tick(1);
        check("link_state", 8'(link_state), 8'(st));
        if (link_state !== st) final_report();
    endtask
    task automatic write_state(input logic [1:0] s);
        pwr_state_data = s;
        pwr_state_wr = 1'b1;
        tick(1);
        pwr_state_wr = 1'b0;
    endtask
    task automatic start(input logic [1:0] gen, input logic async_in);
        nrst = 1'b0;
        train_done = 1'b0;
        link_gen = gen;
        async_refclk = async_in;
        tick(2);
        check("fts_count", fts_count, 8'h00_FF);
        nrst = 1'b1;
        train_done = 1'b1;
        wait_link(plph_pkg::PLPH_LINK_L0);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    initial begin
        {nrst, train_done, async_refclk, pwr_state_wr, turn_off_msg, link_idle, l1_dllp_ack, send_req} = '0;
        {link_gen, pwr_state_data, req_beats} = '0;
        // idle reaches L0s only on synchronous first/second generation builds
        for (int c = 0; c < 3; c++) begin
            start(c == 2 ? plph_pkg::GEN3 : 2'h0, c == 1);
            link_idle = 1'b1;
            tick(plph_pkg::L0S_IDLE_CYC + 8);
            check("l0s", 8'(link_state), c == 0 ? 8'(plph_pkg::PLPH_LINK_L0S) : 8'(plph_pkg::PLPH_LINK_L0));
            link_idle = 1'b0;
            wait_link(plph_pkg::PLPH_LINK_L0);
            $display("idle test %0d done", c);
        end
        // low power states entered with a packet still open
        for (int s = 1; s < 4; s++) begin
            send_req = 1'b1;
            req_beats = 4'h4;
            tick(1);
            send_req = 1'b0;
            write_state(2'(s));
            tick(1);
            check("power_state", 8'(u_if.function_power_state), 8'(s));
            check("ready_open", 8'(u_if.requester_request_ready), 8'h01);
            for (i = 0; i < 40 && busy; i++) tick(1);
            check("busy", 8'(busy), 8'h00);
            if (busy) final_report();
            tick(2);
            check("ready_stall", 8'(u_if.requester_request_ready), 8'h00);
            wait_link(plph_pkg::PLPH_LINK_L1);
            check("dllp_req", 8'(pm_dllp_send), 8'h01);
            l1_dllp_ack = 1'b1;
            tick(4);
            check("dllp_done", 8'(pm_dllp_send), 8'h00);
            l1_dllp_ack = 1'b0;
            write_state(plph_pkg::PWR_D0);
            wait_link(plph_pkg::PLPH_LINK_L0);
            check("ready_back", 8'(u_if.requester_request_ready), 8'h01);
            $display("power state %0d test done", s);
        end
        // turn-off handshake, then a second message that must be ignored
        for (int k = 0; k < 2; k++) begin
            turn_off_msg = 1'b1;
            tick(1);
            turn_off_msg = 1'b0;
            if (k == 0) begin
                check("notice", 8'(u_if.turn_off_notice), 8'h01);
                check("l23", 8'(link_state), 8'(plph_pkg::PLPH_LINK_L23));
                ack_seen = 1'b0;
                for (i = 0; i < 40 && !powered_down; i++) begin
                    tick(1);
                    ack_seen |= turn_off_ack_send;
                end
                check("powered_down", 8'(powered_down), 8'h01);
                if (!powered_down) final_report();
                check("ack_send", 8'(ack_seen), 8'h01);
                wait_link(plph_pkg::PLPH_LINK_OFF);
                check("layers", 8'(layers_enabled), 8'h00);
            end else begin
                tick(3);
                check("notice_again", 8'(u_if.turn_off_notice), 8'h00);
            end
        end
        $display("turn-off test done");
        final_report();
    end
endmodule
